// file: design/pmc_regs.svh
/*
  Constants of the programmable-logic port block: reset values, field
  positions and widths.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// Operation
// - Host loads output cells, reads both cell kinds
// - Eight cells on ports A/B, eight on B/C
// - XOR stage sets each cell's term polarity
// - Cell borrows unused neighbour product terms
// - Mux picks registered or combinatorial cell output
// - Selected output drives pin and feeds array
// - Storage element acts as D, T, JK, SR
// - Clock, preset, clear from terms; clock pin option
// - Pin driver enable is term OR direction
// - Without enable term, direction alone drives enable
// - Direction registers written and read back by host; input cell control write-only
// - Input cells latch, register or pass through
// - Input cells clocked by strobe or term
// - Input cells feed array bus and host reads
// - Programmed port modes fixed at run time
// - Other modes changed by host, applied immediately
// - Two external selects, one term, polarity choice
// - Select pin enable from term or direction
`define PMC_PORT_W        8
`define PMC_CELLS_PER_GRP 8
`define PMC_DIR_RST       8'h00
`define PMC_IMC_RST       8'h00
`define PMC_OMC_RST       1'b0
`define PMC_IMC_MODE_LSB  0
`define PMC_IMC_MODE_MSB  1
`define PMC_IMC_SRC_BIT   2
`define PMC_ECS0_DIR_BIT  2
`define PMC_ECS1_DIR_BIT  3
`endif

// file: design/pmc_pkg.sv
/*
  Types of the programmable-logic port block.
  Assumes the constants header is on the include path.
*/
`include "pmc_regs.svh"
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_FF_D  = 2'h0,
    PMC_FF_T  = 2'h1,
    PMC_FF_JK = 2'h3,
    PMC_FF_SR = 2'h2
  } pmc_ff_t;
  typedef enum logic [1:0] {
    PMC_IMC_PASS  = 2'h0,
    PMC_IMC_LATCH = 2'h1,
    PMC_IMC_REG   = 2'h3
  } pmc_imc_mode_t;
  typedef enum logic {
    PMC_CLK_TERM = 1'b0,
    PMC_CLK_PIN  = 1'b1
  } pmc_clk_src_t;
endpackage : pmc_pkg

// file: design/pmc_out_cell.sv
/*
  One output logic cell: polarity XOR, configurable storage element,
  registered/combinatorial select.
  Assumes all inputs synchronous to core_clk_i; term and pin clocks act on their rising edges.
*/
`timescale 1ns/1ps
`include "pmc_regs.svh"
module pmc_out_cell (
  input  wire logic                  core_clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  term_a_i,
  input  wire logic                  term_b_i,
  input  wire logic                  invert_i,
  input  wire pmc_pkg::pmc_ff_t      ff_type_i,
  input  wire logic                  comb_sel_i,
  input  wire pmc_pkg::pmc_clk_src_t clk_src_i,
  input  wire logic                  pt_clk_i,
  input  wire logic                  pin_clk_i,
  input  wire logic                  pt_preset_i,
  input  wire logic                  pt_clear_i,
  input  wire logic                  host_load_i,
  input  wire logic                  host_data_i,
  output logic                       cell_out_o,
  output logic                       ff_q_o
);
  import pmc_pkg::*;
  logic pt_clk_d_r;
  logic pin_clk_d_r;
  logic ff_q_r;
  logic ff_q_nxt;
  logic data_t;
  logic clk_edge;

  assign data_t = term_a_i ^ invert_i;
  assign clk_edge = (clk_src_i == PMC_CLK_PIN) ? (pin_clk_i & ~pin_clk_d_r)
                                               : (pt_clk_i & ~pt_clk_d_r);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pt_clk_d_r  <= 1'b0;
      pin_clk_d_r <= 1'b0;
    end else begin
      pt_clk_d_r  <= pt_clk_i;
      pin_clk_d_r <= pin_clk_i;
    end
  end

  always_comb begin
    ff_q_nxt = ff_q_r;
    case (ff_type_i)
      PMC_FF_D:  ff_q_nxt = data_t;
      PMC_FF_T:  ff_q_nxt = ff_q_r ^ data_t;
      PMC_FF_JK: ff_q_nxt = (data_t & ~ff_q_r) | (~term_b_i & ff_q_r);
      PMC_FF_SR: ff_q_nxt = data_t | (~term_b_i & ff_q_r);
      default:   ff_q_nxt = ff_q_r;
    endcase
  end

  // Host load first, then clear, then preset, then clock
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ff_q_r <= `PMC_OMC_RST;
    end else if (host_load_i) begin
      ff_q_r <= host_data_i;
    end else if (pt_clear_i) begin
      ff_q_r <= 1'b0;
    end else if (pt_preset_i) begin
      ff_q_r <= 1'b1;
    end else if (clk_edge) begin
      ff_q_r <= ff_q_nxt;
    end
  end

  assign cell_out_o = comb_sel_i ? data_t : ff_q_r;
  assign ff_q_o     = ff_q_r;

  property p_t_toggle;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (clk_edge && !host_load_i && !pt_clear_i && !pt_preset_i
       && ff_type_i == PMC_FF_T && data_t) |=> (ff_q_r != $past(ff_q_r));
  endproperty
  a_t_toggle: assert property (p_t_toggle) else $error("T cell did not toggle");

  property p_pin_clock;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (clk_src_i == PMC_CLK_PIN && pin_clk_i && !pin_clk_d_r && ff_type_i == PMC_FF_D
       && !host_load_i && !pt_clear_i && !pt_preset_i) |=> (ff_q_o == $past(data_t));
  endproperty
  a_pin_clock: assert property (p_pin_clock) else $error("Pin clock missed");

  property p_clear;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (pt_clear_i && !host_load_i) |=> (ff_q_o == 1'b0);
  endproperty
  a_clear: assert property (p_clear) else $error("Clear term ignored");

  property p_mux;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      !comb_sel_i |-> (cell_out_o == ff_q_o);
  endproperty
  a_mux: assert property (p_mux) else $error("Registered path not selected");
endmodule : pmc_out_cell

// file: design/pmc_port_io.sv
/*
  Programmable-logic port block: sixteen output cells, input cells on
  ports A to C, pin driver enables, two external selects.
  Assumes product terms come from the logic array as synchronous inputs,
  and programmed configuration inputs are static; they are captured once
  on the first clock after reset release.
*/
`timescale 1ns/1ps
`include "pmc_regs.svh"
module pmc_port_io #(
  parameter int PORT_W = `PMC_PORT_W,
  parameter int GRP_N  = `PMC_CELLS_PER_GRP
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  arst_n_i,
  // Product terms from the array, cells 0..7 first pair, 8..15 second
  input  wire logic [2*GRP_N-1:0]    pt_term_i,
  input  wire logic [2*GRP_N-1:0]    pt_k_i,
  input  wire logic [2*GRP_N-1:0]    pt_clk_i,
  input  wire logic [2*GRP_N-1:0]    pt_preset_i,
  input  wire logic [2*GRP_N-1:0]    pt_clear_i,
  input  wire logic [PORT_W-1:0]     pt_oe_a_i,
  input  wire logic [PORT_W-1:0]     pt_oe_b_i,
  input  wire logic [PORT_W-1:0]     pt_oe_c_i,
  input  wire logic [2:0]            pt_imc_clk_i,
  input  wire logic [1:0]            ecs_pt_i,
  input  wire logic [1:0]            ecs_oe_pt_i,
  input  wire logic                  ale_i,
  input  wire logic                  port_d_bit_one_i,
  // Programmed configuration
  input  wire logic [2*GRP_N-1:0]    cfg_invert_i,
  input  wire pmc_pkg::pmc_ff_t      cfg_ff_type_i [2*GRP_N],
  input  wire logic [2*GRP_N-1:0]    cfg_comb_sel_i,
  input  wire logic [2*GRP_N-1:0]    cfg_clk_pin_i,
  input  wire logic [2*GRP_N-1:0]    cfg_borrow_i,
  input  wire logic [2*GRP_N-1:0]    cfg_native_used_i,
  input  wire logic [2*GRP_N-1:0]    cfg_pin_en_i,
  input  wire logic [GRP_N-1:0]      cfg_ab_on_b_i,
  input  wire logic [GRP_N-1:0]      cfg_bc_on_c_i,
  input  wire logic [PORT_W-1:0]     cfg_oe_def_a_i,
  input  wire logic [PORT_W-1:0]     cfg_oe_def_b_i,
  input  wire logic [PORT_W-1:0]     cfg_oe_def_c_i,
  input  wire logic [1:0]            cfg_ecs_act_high_i,
  input  wire logic [1:0]            cfg_ecs_oe_pt_i,
  // Host side
  input  wire logic [PORT_W-1:0]     host_data_i,
  input  wire logic                  omc_ab_wr_i,
  input  wire logic                  omc_bc_wr_i,
  input  wire logic [3:0]            dir_wr_i,
  input  wire logic [2:0]            imc_ctl_wr_i,
  output logic [GRP_N-1:0]           omc_ab_rd_o,
  output logic [GRP_N-1:0]           omc_bc_rd_o,
  output logic [PORT_W-1:0]          imc_a_rd_o,
  output logic [PORT_W-1:0]          imc_b_rd_o,
  output logic [PORT_W-1:0]          imc_c_rd_o,
  output logic [PORT_W-1:0]          dir_a_rd_o,
  output logic [PORT_W-1:0]          dir_b_rd_o,
  output logic [PORT_W-1:0]          dir_c_rd_o,
  output logic [PORT_W-1:0]          dir_d_rd_o,
  // Pins
  input  wire logic [PORT_W-1:0]     port_a_in_i,
  input  wire logic [PORT_W-1:0]     port_b_in_i,
  input  wire logic [PORT_W-1:0]     port_c_in_i,
  input  wire logic [PORT_W-1:0]     port_a_dout_i,
  input  wire logic [PORT_W-1:0]     port_b_dout_i,
  input  wire logic [PORT_W-1:0]     port_c_dout_i,
  output logic [PORT_W-1:0]          port_a_out_o,
  output logic [PORT_W-1:0]          port_a_oe_o,
  output logic [PORT_W-1:0]          port_b_out_o,
  output logic [PORT_W-1:0]          port_b_oe_o,
  output logic [PORT_W-1:0]          port_c_out_o,
  output logic [PORT_W-1:0]          port_c_oe_o,
  output logic [1:0]                 external_select_outputs_o,
  output logic [1:0]                 external_select_oe_o,
  // Array feedback
  output logic [2*GRP_N-1:0]         fb_o,
  output logic [3*PORT_W-1:0]        imc_bus_o
);
  import pmc_pkg::*;
  localparam int NC = 2 * GRP_N;

  logic                 cfg_loaded_r;
  logic [NC-1:0]        invert_r;
  pmc_ff_t              ff_type_r [NC];
  logic [NC-1:0]        comb_sel_r;
  logic [NC-1:0]        clk_pin_r;
  logic [NC-1:0]        borrow_r;
  logic [NC-1:0]        native_used_r;
  logic [NC-1:0]        pin_en_r;
  logic [GRP_N-1:0]     ab_on_b_r;
  logic [GRP_N-1:0]     bc_on_c_r;
  logic [PORT_W-1:0]    oe_def_r [3];
  logic [1:0]           ecs_act_high_r;
  logic [1:0]           ecs_oe_pt_r;
  logic [PORT_W-1:0]    dir_r [4];
  pmc_imc_mode_t        imc_mode_r [3];
  logic [2:0]           imc_src_ale_r;
  logic                 strobe_d_r [3];
  logic [PORT_W-1:0]    imc_q_r [3];
  logic [PORT_W-1:0]    imc_val [3];
  logic [PORT_W-1:0]    pin_in [3];
  logic [2:0]           strobe;
  logic [NC-1:0]        sum_term;
  logic [NC-1:0]        cell_out;
  logic [NC-1:0]        cell_q;
  logic [PORT_W-1:0]    a_pld;
  logic [PORT_W-1:0]    b_ab;
  logic [PORT_W-1:0]    b_bc;
  logic [PORT_W-1:0]    c_pld;

  // Programmed modes frozen after the first clock
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_loaded_r   <= 1'b0;
      invert_r       <= '0;
      comb_sel_r     <= '0;
      clk_pin_r      <= '0;
      borrow_r       <= '0;
      native_used_r  <= '0;
      pin_en_r       <= '0;
      ab_on_b_r      <= '0;
      bc_on_c_r      <= '0;
      ecs_act_high_r <= '0;
      ecs_oe_pt_r    <= '0;
      for (int i = 0; i < 3; i++) begin
        oe_def_r[i] <= '0;
      end
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r   <= 1'b1;
      invert_r       <= cfg_invert_i;
      comb_sel_r     <= cfg_comb_sel_i;
      clk_pin_r      <= cfg_clk_pin_i;
      borrow_r       <= cfg_borrow_i;
      native_used_r  <= cfg_native_used_i;
      pin_en_r       <= cfg_pin_en_i;
      ab_on_b_r      <= cfg_ab_on_b_i;
      bc_on_c_r      <= cfg_bc_on_c_i;
      ecs_act_high_r <= cfg_ecs_act_high_i;
      ecs_oe_pt_r    <= cfg_ecs_oe_pt_i;
      oe_def_r[0]    <= cfg_oe_def_a_i;
      oe_def_r[1]    <= cfg_oe_def_b_i;
      oe_def_r[2]    <= cfg_oe_def_c_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NC; i++) begin
        ff_type_r[i] <= PMC_FF_D;
      end
    end else if (!cfg_loaded_r) begin
      for (int i = 0; i < NC; i++) begin
        ff_type_r[i] <= cfg_ff_type_i[i];
      end
    end
  end

  // Direction registers, written at run time
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int p = 0; p < 4; p++) begin
        dir_r[p] <= `PMC_DIR_RST;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (dir_wr_i[p]) begin
          dir_r[p] <= host_data_i;
        end
      end
    end
  end

  assign dir_a_rd_o = dir_r[0];
  assign dir_b_rd_o = dir_r[1];
  assign dir_c_rd_o = dir_r[2];
  assign dir_d_rd_o = dir_r[3];

  // Output cells; each may borrow its pair neighbour's idle term
  for (genvar i = 0; i < NC; i++) begin : g_cell
    assign sum_term[i] = pt_term_i[i]
                       | (borrow_r[i] & ~native_used_r[i ^ 1] & pt_term_i[i ^ 1]);
    pmc_out_cell u_cell (
      .core_clk_i  (core_clk_i),
      .arst_n_i    (arst_n_i),
      .term_a_i    (sum_term[i]),
      .term_b_i    (pt_k_i[i]),
      .invert_i    (invert_r[i]),
      .ff_type_i   (ff_type_r[i]),
      .comb_sel_i  (comb_sel_r[i]),
      .clk_src_i   (clk_pin_r[i] ? PMC_CLK_PIN : PMC_CLK_TERM),
      .pt_clk_i    (pt_clk_i[i]),
      .pin_clk_i   (port_d_bit_one_i),
      .pt_preset_i (pt_preset_i[i]),
      .pt_clear_i  (pt_clear_i[i]),
      .host_load_i (i < GRP_N ? omc_ab_wr_i : omc_bc_wr_i),
      .host_data_i (host_data_i[i % GRP_N]),
      .cell_out_o  (cell_out[i]),
      .ff_q_o      (cell_q[i])
    );
  end

  assign fb_o        = cell_out;
  assign omc_ab_rd_o = cell_q[GRP_N-1:0];
  assign omc_bc_rd_o = cell_q[NC-1:GRP_N];

  // Pin routing of the cells
  assign a_pld = pin_en_r[GRP_N-1:0] & ~ab_on_b_r;
  assign b_ab  = pin_en_r[GRP_N-1:0] & ab_on_b_r;
  assign b_bc  = pin_en_r[NC-1:GRP_N] & ~bc_on_c_r & ~b_ab;
  assign c_pld = pin_en_r[NC-1:GRP_N] & bc_on_c_r;

  always_comb begin
    for (int b = 0; b < PORT_W; b++) begin
      port_a_out_o[b] = a_pld[b] ? cell_out[b] : port_a_dout_i[b];
      port_b_out_o[b] = b_ab[b] ? cell_out[b]
                      : (b_bc[b] ? cell_out[GRP_N+b] : port_b_dout_i[b]);
      port_c_out_o[b] = c_pld[b] ? cell_out[GRP_N+b] : port_c_dout_i[b];
    end
  end

  // Undefined enable terms are masked off, leaving direction alone
  assign port_a_oe_o = (pt_oe_a_i & oe_def_r[0]) | dir_r[0];
  assign port_b_oe_o = (pt_oe_b_i & oe_def_r[1]) | dir_r[1];
  assign port_c_oe_o = (pt_oe_c_i & oe_def_r[2]) | dir_r[2];

  // External selects
  assign external_select_outputs_o = ~(ecs_pt_i ^ ecs_act_high_r);
  assign external_select_oe_o[0] = ecs_oe_pt_r[0] ? ecs_oe_pt_i[0]
                                                  : dir_r[3][`PMC_ECS0_DIR_BIT];
  assign external_select_oe_o[1] = ecs_oe_pt_r[1] ? ecs_oe_pt_i[1]
                                                  : dir_r[3][`PMC_ECS1_DIR_BIT];

  // Input cell control, written at run time
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      imc_src_ale_r <= '0;
      for (int p = 0; p < 3; p++) begin
        imc_mode_r[p] <= PMC_IMC_PASS;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (imc_ctl_wr_i[p]) begin
          imc_mode_r[p] <= pmc_imc_mode_t'(host_data_i[`PMC_IMC_MODE_MSB:`PMC_IMC_MODE_LSB]);
          imc_src_ale_r[p] <= host_data_i[`PMC_IMC_SRC_BIT];
        end
      end
    end
  end

  assign pin_in[0] = port_a_in_i;
  assign pin_in[1] = port_b_in_i;
  assign pin_in[2] = port_c_in_i;

  for (genvar p = 0; p < 3; p++) begin : g_imc
    assign strobe[p] = imc_src_ale_r[p] ? ale_i : pt_imc_clk_i[p];

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        strobe_d_r[p] <= 1'b0;
        imc_q_r[p]    <= `PMC_IMC_RST;
      end else begin
        strobe_d_r[p] <= strobe[p];
        if (imc_mode_r[p] == PMC_IMC_LATCH && strobe[p]) begin
          imc_q_r[p] <= pin_in[p];
        end else if (imc_mode_r[p] == PMC_IMC_REG && strobe[p] && !strobe_d_r[p]) begin
          imc_q_r[p] <= pin_in[p];
        end
      end
    end

    always_comb begin
      case (imc_mode_r[p])
        PMC_IMC_LATCH: imc_val[p] = strobe[p] ? pin_in[p] : imc_q_r[p];
        PMC_IMC_REG:   imc_val[p] = imc_q_r[p];
        default:       imc_val[p] = pin_in[p];
      endcase
    end

    assign imc_bus_o[p*PORT_W +: PORT_W] = imc_val[p];
  end

  assign imc_a_rd_o = imc_val[0];
  assign imc_b_rd_o = imc_val[1];
  assign imc_c_rd_o = imc_val[2];

  property p_dir_reset;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      !cfg_loaded_r |-> (dir_a_rd_o == 8'h00 && dir_d_rd_o == 8'h00 && port_a_oe_o == 8'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("Direction not clear after reset");

  property p_dir_write;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      dir_wr_i[1] |=> (dir_b_rd_o == $past(host_data_i));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("Direction readback wrong");

  property p_oe_dir;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      dir_wr_i[0] ##1 !dir_wr_i[0] |-> ((port_a_oe_o & $past(host_data_i, 1)) == $past(host_data_i, 1));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("Direction bit did not enable driver");

  property p_oe_sole;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (cfg_loaded_r && oe_def_r[2] == 8'h00) |-> (port_c_oe_o == dir_c_rd_o);
  endproperty
  a_oe_sole: assert property (p_oe_sole) else $error("Undefined enable term leaked");

  property p_cfg_fixed;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      cfg_loaded_r ##1 1'b1 |-> ($stable(invert_r) && $stable(pin_en_r) && $stable(comb_sel_r));
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("Programmed mode changed");

  property p_omc_load;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      omc_bc_wr_i |=> (omc_bc_rd_o == $past(host_data_i));
  endproperty
  a_omc_load: assert property (p_omc_load) else $error("Output cell load lost");

  property p_imc_reg;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (imc_mode_r[0] == PMC_IMC_REG && strobe[0] && !strobe_d_r[0] && !imc_ctl_wr_i[0])
        |=> (imc_a_rd_o == $past(port_a_in_i));
  endproperty
  a_imc_reg: assert property (p_imc_reg) else $error("Input register missed strobe");

  property p_imc_pass;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      imc_ctl_wr_i[1] && host_data_i[1:0] == 2'h0 |=> (imc_bus_o[15:8] == port_b_in_i);
  endproperty
  a_imc_pass: assert property (p_imc_pass) else $error("Pass-through input wrong");

  property p_ecs_level;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      ecs_pt_i[0] |-> (external_select_outputs_o[0] == ecs_act_high_r[0]);
  endproperty
  a_ecs_level: assert property (p_ecs_level) else $error("Select polarity wrong");

  property p_ecs_oe;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      !ecs_oe_pt_r[1] |-> (external_select_oe_o[1] == dir_d_rd_o[`PMC_ECS1_DIR_BIT]);
  endproperty
  a_ecs_oe: assert property (p_ecs_oe) else $error("Select enable not from direction");
endmodule : pmc_port_io

// file: tb/pmc_pin_model.sv
/*
  Pin-side model of one eight-bit port: resolves each pin's level.
  Assumes the bench supplies the level that outside parts put on idle pins.
*/
`timescale 1ns/1ps
module pmc_pin_model (
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_o
);
  // Driven bits follow the block, released bits follow the outside
  always_comb pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : pmc_pin_model

// file: tb/tb.sv
/*
  Bench for the programmable-logic port block: cell modes, host loads,
  pin enables, external selects and input cells.
  Assumes the package, the design files and the pin model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  logic        clk, rst_n, ale, dclk, wab, wbc;
  logic [15:0] term, k, pclk, pre, clr, inv, comb, cpin, brw, nat, pen, fb;
  logic [7:0]  oea, oeb, oec, defa, defb, defc, abb, bcc, hd, dout, exa, exb, exc;
  logic [7:0]  pa, pb, pc, mab, mbc, ia, ib, ic, da, db, dc, dd, ao, ae, bo, be, co, ce;
  logic [3:0]  dwr;
  logic [2:0]  imclk, iwr;
  logic [1:0]  ecs, ecsoe, act, eoc, eo, eoe;
  logic [23:0] ibus;
  pmc_ff_t     fft [16];
  int          failures, checks;

  pmc_port_io u_pmc_port_io (
    .core_clk_i(clk), .arst_n_i(rst_n), .pt_term_i(term), .pt_k_i(k), .pt_clk_i(pclk),
    .pt_preset_i(pre), .pt_clear_i(clr), .pt_oe_a_i(oea), .pt_oe_b_i(oeb), .pt_oe_c_i(oec),
    .pt_imc_clk_i(imclk), .ecs_pt_i(ecs), .ecs_oe_pt_i(ecsoe), .ale_i(ale),
    .port_d_bit_one_i(dclk), .cfg_invert_i(inv), .cfg_ff_type_i(fft), .cfg_comb_sel_i(comb),
    .cfg_clk_pin_i(cpin), .cfg_borrow_i(brw), .cfg_native_used_i(nat), .cfg_pin_en_i(pen),
    .cfg_ab_on_b_i(abb), .cfg_bc_on_c_i(bcc), .cfg_oe_def_a_i(defa), .cfg_oe_def_b_i(defb),
    .cfg_oe_def_c_i(defc), .cfg_ecs_act_high_i(act), .cfg_ecs_oe_pt_i(eoc),
    .host_data_i(hd), .omc_ab_wr_i(wab), .omc_bc_wr_i(wbc), .dir_wr_i(dwr),
    .imc_ctl_wr_i(iwr), .omc_ab_rd_o(mab), .omc_bc_rd_o(mbc), .imc_a_rd_o(ia),
    .imc_b_rd_o(ib), .imc_c_rd_o(ic), .dir_a_rd_o(da), .dir_b_rd_o(db), .dir_c_rd_o(dc),
    .dir_d_rd_o(dd), .port_a_in_i(pa), .port_b_in_i(pb), .port_c_in_i(pc),
    .port_a_dout_i(dout), .port_b_dout_i(dout), .port_c_dout_i(dout), .port_a_out_o(ao),
    .port_a_oe_o(ae), .port_b_out_o(bo), .port_b_oe_o(be), .port_c_out_o(co),
    .port_c_oe_o(ce), .external_select_outputs_o(eo), .external_select_oe_o(eoe),
    .fb_o(fb), .imc_bus_o(ibus));
  pmc_pin_model u_pmc_pin_model_a (.out_i(ao), .oe_i(ae), .ext_i(exa), .pin_o(pa));
  pmc_pin_model u_pmc_pin_model_b (.out_i(bo), .oe_i(be), .ext_i(exb), .pin_o(pb));
  pmc_pin_model u_pmc_pin_model_c (.out_i(co), .oe_i(ce), .ext_i(exc), .pin_o(pc));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask : step

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Select 0..3 direction A..D, 4/5 cell groups, 6..8 input cell control A..C
  task automatic wr(input int sel, input logic [7:0] d);
    hd = d;
    if (sel < 4) dwr[sel] = 1'b1;
    else if (sel == 4) wab = 1'b1;
    else if (sel == 5) wbc = 1'b1;
    else iwr[sel-6] = 1'b1;
    step();
    {dwr, wab, wbc, iwr} = '0;
    step();
  endtask : wr

  // Cells 1, 3, 4 clocked by term, cell 2 by the clock pin
  task automatic pulse();
    pclk = 16'h001a;
    dclk = 1'b1;
    step();
    pclk = '0;
    dclk = 1'b0;
    step();
  endtask : pulse

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial begin
    {rst_n, ale, dclk, wab, wbc, dwr, imclk, iwr, hd, dout, ecs, ecsoe} = '0;
    {term, k, pclk, pre, clr, brw, abb, bcc, oea, oeb, oec, defb, defc} = '0;
    {exa, exb, exc} = '0;
    nat = 16'hffff;
    cpin = 16'h0004;
    {pen, inv, comb} = {3{16'h0001}};
    defa = 8'h0f;
    act = 2'b01;
    eoc = 2'b01;
    foreach (fft[i]) fft[i] = PMC_FF_D;
    fft[2] = PMC_FF_T;
    fft[3] = PMC_FF_JK;
    fft[4] = PMC_FF_SR;
    step(5);
    chk("dir reset", 0, {da, db, dc, dd});
    chk("oe reset", 0, {ae, be, ce, 6'h0, eoe});
    rst_n = 1'b1;
    step(2);
    term[0] = 1'b1;
    #1 chk("cell0 fb", 0, fb[0]);
    chk("cell0 pin", 0, ao[0]);
    term[0] = 1'b0;
    #1 chk("cell0 fb", 1, fb[0]);
    inv[0] = 1'b0;
    step();
    chk("fixed polarity", 1, fb[0]);
    term[4:1] = 4'hf;
    k[3] = 1'b1;
    pulse();
    chk("cells 4..1", 4'hf, mab[4:1]);
    chk("cell1 fb", 1, fb[1]);
    term[4:1] = 4'he;
    pulse();
    chk("cells 4..1", 4'h8, mab[4:1]);
    term[4:1] = 4'h0;
    k[4] = 1'b1;
    pulse();
    chk("cells 4..1", 4'h0, mab[4:1]);
    term[2] = 1'b1;
    pclk[2] = 1'b1;
    step(2);
    pclk = '0;
    step();
    chk("pin clocked cell", 0, mab[2]);
    term[2] = 1'b0;
    pre[1] = 1'b1;
    step();
    chk("preset", 1, mab[1]);
    clr[1] = 1'b1;
    step();
    chk("clear over preset", 0, mab[1]);
    {pre, clr} = '0;
    wr(4, 8'ha5);
    chk("group ab load", 8'ha5, mab);
    wr(5, 8'h3c);
    chk("group bc load", 8'h3c, mbc);
    oea = 8'hff;
    for (int i = 0; i < 4; i++) wr(i, 8'(i * 16 + 9));
    chk("directions", 32'h09192939, {da, db, dc, dd});
    chk("pin enables", 24'h0f1929, {ae, be, ce});
    oea = 8'h00;
    #1 chk("dir only enable", 8'h09, ae);
    chk("select enables", 2'b10, eoe);
    ecsoe = 2'b11;
    wr(3, 8'h00);
    chk("select enables", 2'b01, eoe);
    ecs = 2'b11;
    #1 chk("selects", 2'b01, eo);
    ecs = 2'b00;
    #1 chk("selects", 2'b10, eo);
    for (int i = 0; i < 3; i++) wr(i, 8'h00);
    exa = 8'h5a;
    exc = 8'h9c;
    #1 chk("pass a", 8'h5a, ia);
    chk("array bus", 24'h9c005a, {ibus[23:16], 8'h0, ibus[7:0]});
    chk("pass c", 8'h9c, ic);
    wr(6, 8'h07);
    exa = 8'h66;
    ale = 1'b1;
    step();
    ale = 1'b0;
    exa = 8'h77;
    step(2);
    chk("registered a", 8'h66, ia);
    wr(7, 8'h01);
    exb = 8'h21;
    imclk[1] = 1'b1;
    step();
    chk("latch open b", 8'h21, ib);
    imclk[1] = 1'b0;
    step();
    exb = 8'h43;
    #1 chk("latch shut b", 8'h21, ib);
    wr(0, 8'hff);
    rst_n = 1'b0;
    dout = 8'h3c;
    nat = 16'hfffe;
    brw = 16'h0002;
    bcc = 8'h01;
    {pen, comb} = {2{16'h0102}};
    {inv, term} = '0;
    step();
    chk("dir reset again", 0, da);
    rst_n = 1'b1;
    step(2);
    term[0] = 1'b1;
    term[8] = 1'b1;
    #1 chk("borrowed term", 1, fb[1]);
    chk("borrowed pin", 8'h3e, ao);
    chk("second group on c", 8'h3d, co);
    chk("port b data", 8'h3c, bo);
    report_and_stop();
  end
endmodule : tb
